// File: rtl/alert_mask_store.v
// per status code alert suppress masks and the gated alert request
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_config_regs.vh"

module alert_mask_store (
  input wire i_clk,
  input wire i_rst,
  input wire i_wr,
  input wire [7:0] i_code,
  input wire [7:0] i_wdata,
  input wire [31:0] i_status,
  output wire o_code_ok,
  output wire [7:0] o_rdata,
  output wire o_alert
);
  localparam [31:0] WRITABLE = {`MASK_WRITABLE_TEMP, `MASK_WRITABLE_INPUT,
    `MASK_WRITABLE_IOUT, `MASK_WRITABLE_VOUT};
  wire [7:0] offs;
  wire [1:0] idx;
  wire [31:0] masks;
  wire [3:0] hits;
  assign offs = i_code - `STATUS_CODE_FIRST;
  assign idx = offs[1:0];
  assign o_code_ok = (offs < `STATUS_CODE_COUNT);

  genvar g;
  generate
    for (g = 0; g < `STATUS_CODE_COUNT; g = g + 1) begin : entry
      reg [7:0] mask;
      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          mask <= `MASK_RESET;
        end else if (i_wr && o_code_ok && idx == g) begin
          mask <= i_wdata & WRITABLE[8*g +: 8];
        end
      end
      assign masks[8*g +: 8] = mask;
      // status bit still sets; mask only gates the alert
      assign hits[g] = |(i_status[8*g +: 8] & ~mask);
    end
  endgenerate

  assign o_rdata = masks[8*idx +: 8];
  assign o_alert = |hits;
endmodule // alert_mask_store
`default_nettype wire

// File: rtl/pmbus_config_command_group.v
// command handling for phase, write lock, save/restore, features, masks
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_config_regs.vh"

// Operation
// - phase selection resets to all phases; 00h-03h pick phases one to four
// - phase values 04h-FEh or beyond stack size flag invalid data
// - lock level 00h lets every supported write through
// - lock 20h allows only lock, operation, switch setup, save, setpoint
// - lock 40h allows only lock, operation and save writes
// - lock 80h allows only lock and save writes
// - lock values other than 00h/20h/40h/80h flag invalid data
// - reads always answered, whatever the lock level
// - save copies operating memory into user store, skipping unmatched items
// - during an nvm store commands are stalled or ignored
// - restore disables regulation, loads user store, then applies straps
// - feature report bit7 set, bits6:5 10b, bit4 set
// - feature report bit3 zero, bit2 zero, bits1:0 zero
// - any write to the feature report flags invalid data
// - set mask bit blocks alert but status bit still sets
// - mask write is write word: low byte code, high byte mask
// - mask read is process call: code in, one-byte mask out
// - mask command only works while all phases are selected
// - selected phase applies to later commands until changed
module pmbus_config_command_group (
  input wire i_clk,
  input wire i_rst,
  input wire i_cmd_valid,
  input wire [2:0] i_cmd_kind,
  input wire [7:0] i_cmd_code,
  input wire [7:0] i_wdata_lo,
  input wire [7:0] i_wdata_hi,
  input wire [2:0] i_phase_count,
  input wire [31:0] i_status,
  input wire i_nvm_done,
  output wire o_cmd_ready,
  output reg o_rvalid,
  output reg [7:0] o_rdata,
  output reg o_write_ok,
  output reg o_lock_reject,
  output reg o_invalid_data,
  output reg o_unsupported_cmd,
  output reg [7:0] o_phase,
  output reg [7:0] o_lock_level,
  output reg o_nvm_save_req,
  output reg o_nvm_load_req,
  output reg o_regulation_off,
  output reg o_strap_apply,
  output wire o_smbalert_out,
  output wire o_smbalert_oe
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SAVE = 4'h2;
  localparam [3:0] ST_LOAD = 4'h4;
  localparam [3:0] ST_STRAP = 4'h8;

  localparam [7:0] FEATURE =
    ({7'h00, `FEAT_PEC} << `FEAT_PEC_BIT) |
    ({6'h00, `FEAT_SPEED} << `FEAT_SPEED_LSB) |
    ({7'h00, `FEAT_ALERT} << `FEAT_ALERT_BIT) |
    ({7'h00, `FEAT_FORMAT} << `FEAT_FORMAT_BIT) |
    ({7'h00, `FEAT_AVS} << `FEAT_AVS_BIT);

  reg [3:0] state;
  reg [3:0] next_state;
  wire lock_ok;
  wire mask_code_ok;
  wire [7:0] mask_rdata;
  wire alert;
  wire take;
  wire is_write;
  wire is_read;
  wire all_phases;
  wire phase_in_stack;
  wire lock_value_ok;
  wire mask_wr;
  wire [7:0] mask_code;
  wire wr_take;
  wire rd_take;
  wire wr_passed;
  wire phase_value_ok;
  wire mask_read_ok;
  wire save_start;
  wire load_start;

  // new commands are stalled while nvm work runs
  assign o_cmd_ready = (state == ST_IDLE);
  assign take = i_cmd_valid & o_cmd_ready;
  assign is_write = (i_cmd_kind == `KIND_SEND_BYTE) |
    (i_cmd_kind == `KIND_WRITE_BYTE) | (i_cmd_kind == `KIND_WRITE_WORD);
  assign is_read = (i_cmd_kind == `KIND_READ_BYTE) |
    (i_cmd_kind == `KIND_PROC_CALL);
  assign all_phases = (o_phase == `PHASE_ALL);
  assign phase_in_stack = (i_wdata_lo <= `PHASE_LAST) &&
    ({5'h00, i_phase_count} > i_wdata_lo);
  assign lock_value_ok = (i_wdata_lo == `LOCK_NONE) |
    (i_wdata_lo == `LOCK_SETPOINT) | (i_wdata_lo == `LOCK_OPERATION) |
    (i_wdata_lo == `LOCK_ALL);
  assign mask_wr = take && lock_ok && all_phases &&
    i_cmd_kind == `KIND_WRITE_WORD &&
    i_cmd_code == `CMD_ALERT_SUPPRESS_MASK;
  assign mask_code = i_wdata_lo;
  assign wr_take = take & is_write;
  assign rd_take = take & is_read;
  // feature report writes are refused before the lock is consulted
  assign wr_passed = wr_take & lock_ok &
    (i_cmd_code != `CMD_FEATURE_REPORT);
  // phases beyond the stack size count as invalid data
  assign phase_value_ok = (i_wdata_lo == `PHASE_ALL) | phase_in_stack;
  // mask reads need the process call form and all phases
  assign mask_read_ok = all_phases & mask_code_ok &
    (i_cmd_kind == `KIND_PROC_CALL);
  // nvm work only starts on writes the lock lets through
  assign save_start = wr_passed & (i_cmd_code == `CMD_SAVE_CONFIG);
  assign load_start = wr_passed & (i_cmd_code == `CMD_LOAD_CONFIG);

  write_lock_filter lock_filter (
    .i_level(o_lock_level),
    .i_cmd_code(i_cmd_code),
    .o_allowed(lock_ok)
  );

  alert_mask_store masks (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr(mask_wr),
    .i_code(mask_code),
    .i_wdata(i_wdata_hi),
    .i_status(i_status),
    .o_code_ok(mask_code_ok),
    .o_rdata(mask_rdata),
    .o_alert(alert)
  );

  // open drain alert: only ever pulls low
  assign o_smbalert_out = 1'b0;
  assign o_smbalert_oe = alert;

  // phase selection register
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_phase <= `PHASE_RESET;
    end else if (wr_passed && i_cmd_code == `CMD_PHASE_SELECT &&
        phase_value_ok) begin
      o_phase <= i_wdata_lo;
    end
  end

  // write lock level register
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lock_level <= `LOCK_RESET;
    end else if (wr_passed && i_cmd_code == `CMD_WRITE_LOCK_LEVEL &&
        lock_value_ok) begin
      o_lock_level <= i_wdata_lo;
    end
  end

  // read answers; reads bypass the write lock entirely
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      o_rvalid <= 1'b0;
      if (rd_take) begin
        case (i_cmd_code)
          `CMD_PHASE_SELECT: begin
            o_rdata <= o_phase;
            o_rvalid <= 1'b1;
          end
          `CMD_WRITE_LOCK_LEVEL: begin
            o_rdata <= o_lock_level;
            o_rvalid <= 1'b1;
          end
          `CMD_FEATURE_REPORT: begin
            o_rdata <= FEATURE;
            o_rvalid <= 1'b1;
          end
          `CMD_ALERT_SUPPRESS_MASK: begin
            if (mask_read_ok) begin
              o_rdata <= mask_rdata;
              o_rvalid <= 1'b1;
            end
          end
          default: o_rvalid <= 1'b0;
        endcase
      end
    end
  end

  // one-cycle result pulses for every taken write and for failed reads
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_write_ok <= 1'b0;
      o_lock_reject <= 1'b0;
      o_invalid_data <= 1'b0;
      o_unsupported_cmd <= 1'b0;
    end else begin
      o_write_ok <= 1'b0;
      o_lock_reject <= 1'b0;
      o_invalid_data <= 1'b0;
      o_unsupported_cmd <= 1'b0;
      if (wr_take) begin
        if (i_cmd_code == `CMD_FEATURE_REPORT) begin
          o_invalid_data <= 1'b1;
        end else if (!lock_ok) begin
          o_lock_reject <= 1'b1;
        end else begin
          case (i_cmd_code)
            `CMD_PHASE_SELECT: begin
              o_write_ok <= phase_value_ok;
              o_invalid_data <= !phase_value_ok;
            end
            `CMD_WRITE_LOCK_LEVEL: begin
              o_write_ok <= lock_value_ok;
              o_invalid_data <= !lock_value_ok;
            end
            `CMD_ALERT_SUPPRESS_MASK: begin
              if (!all_phases) begin
                o_unsupported_cmd <= 1'b1;
              end else if (!mask_code_ok) begin
                o_invalid_data <= 1'b1;
              end else begin
                o_write_ok <= 1'b1;
              end
            end
            default: o_write_ok <= 1'b1;
          endcase
        end
      end else if (rd_take) begin
        case (i_cmd_code)
          `CMD_PHASE_SELECT, `CMD_WRITE_LOCK_LEVEL,
          `CMD_FEATURE_REPORT: o_unsupported_cmd <= 1'b0;
          `CMD_ALERT_SUPPRESS_MASK: begin
            if (!all_phases) begin
              o_unsupported_cmd <= 1'b1;
            end else if (!mask_read_ok) begin
              o_invalid_data <= 1'b1;
            end
          end
          default: o_unsupported_cmd <= 1'b1;
        endcase
      end
    end
  end

  // nvm sequencing
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (save_start) begin
          next_state = ST_SAVE;
        end else if (load_start) begin
          next_state = ST_LOAD;
        end
      end
      ST_SAVE: begin
        // stay busy until the store reports completion
        if (i_nvm_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_LOAD: begin
        if (i_nvm_done) begin
          next_state = ST_STRAP;
        end
      end
      ST_STRAP: begin
        // one cycle for the strap values to overwrite
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // nvm state register
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // nvm request pulses, one cycle each
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_nvm_save_req <= 1'b0;
      o_nvm_load_req <= 1'b0;
      o_regulation_off <= 1'b0;
      o_strap_apply <= 1'b0;
    end else begin
      o_nvm_save_req <= (state == ST_IDLE) && (next_state == ST_SAVE);
      o_nvm_load_req <= (state == ST_IDLE) && (next_state == ST_LOAD);
      // regulation stops before user store is loaded
      o_regulation_off <= (state == ST_IDLE) && (next_state == ST_LOAD);
      o_strap_apply <= (state == ST_LOAD) && (next_state == ST_STRAP);
    end
  end
endmodule // pmbus_config_command_group
`default_nettype wire

// File: rtl/pmbus_config_regs.vh
// command codes, field layouts and reset values for the config command group
`ifndef PMBUS_CONFIG_REGS_VH
`define PMBUS_CONFIG_REGS_VH

`define CMD_OPERATION 8'h01
`define CMD_POWER_SWITCH_SETUP 8'h02
`define CMD_PHASE_SELECT 8'h04
`define CMD_WRITE_LOCK_LEVEL 8'h10
`define CMD_SAVE_CONFIG 8'h15
`define CMD_LOAD_CONFIG 8'h16
`define CMD_FEATURE_REPORT 8'h19
`define CMD_ALERT_SUPPRESS_MASK 8'h1B
`define CMD_OUTPUT_VOLTAGE_SETPOINT 8'h21

`define PHASE_ALL 8'hFF
`define PHASE_RESET 8'hFF
`define PHASE_LAST 8'h03

`define LOCK_NONE 8'h00
`define LOCK_SETPOINT 8'h20
`define LOCK_OPERATION 8'h40
`define LOCK_ALL 8'h80
`define LOCK_RESET 8'h00

// feature report fields
`define FEAT_PEC_BIT 7
`define FEAT_SPEED_LSB 5
`define FEAT_ALERT_BIT 4
`define FEAT_FORMAT_BIT 3
`define FEAT_AVS_BIT 2
`define FEAT_PEC 1'h1
`define FEAT_SPEED 2'h2
`define FEAT_ALERT 1'h1
`define FEAT_FORMAT 1'h0
`define FEAT_AVS 1'h0

// status command codes that own an alert suppress mask
`define STATUS_CODE_FIRST 8'h7A
`define STATUS_CODE_COUNT 4
`define MASK_WRITABLE_VOUT 8'hFC
`define MASK_WRITABLE_IOUT 8'hB0
`define MASK_WRITABLE_INPUT 8'hE8
`define MASK_WRITABLE_TEMP 8'hC0
`define MASK_RESET 8'h00

// transaction kinds on the command port
`define KIND_SEND_BYTE 3'h0
`define KIND_WRITE_BYTE 3'h1
`define KIND_WRITE_WORD 3'h2
`define KIND_READ_BYTE 3'h3
`define KIND_PROC_CALL 3'h4

`endif

// File: rtl/write_lock_filter.v
// decides whether a write is allowed at the present write lock level
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_config_regs.vh"

module write_lock_filter (
  input wire [7:0] i_level,
  input wire [7:0] i_cmd_code,
  output reg o_allowed
);
  wire is_lock;
  wire is_save;
  wire is_oper;
  assign is_lock = (i_cmd_code == `CMD_WRITE_LOCK_LEVEL);
  assign is_save = (i_cmd_code == `CMD_SAVE_CONFIG);
  assign is_oper = (i_cmd_code == `CMD_OPERATION);

  always @* begin
    case (i_level)
      `LOCK_NONE: o_allowed = 1'b1;
      `LOCK_SETPOINT: o_allowed = is_lock | is_save | is_oper |
        (i_cmd_code == `CMD_POWER_SWITCH_SETUP) |
        (i_cmd_code == `CMD_OUTPUT_VOLTAGE_SETPOINT);
      `LOCK_OPERATION: o_allowed = is_lock | is_save | is_oper;
      `LOCK_ALL: o_allowed = is_lock | is_save;
      default: o_allowed = 1'b1;
    endcase
  end
endmodule // write_lock_filter
`default_nettype wire

// File: testbench/pmbus_config_command_group_asserts.sv
// checker for the config command group ports
`timescale 1ns/1ps
`default_nettype none
module pmbus_config_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd_kind,
  input wire logic [7:0] i_cmd_code,
  input wire logic [7:0] i_wdata_lo,
  input wire logic [31:0] i_status,
  input wire logic o_cmd_ready,
  input wire logic o_rvalid,
  input wire logic [7:0] o_rdata,
  input wire logic o_write_ok,
  input wire logic o_lock_reject,
  input wire logic o_invalid_data,
  input wire logic o_unsupported_cmd,
  input wire logic [7:0] o_phase,
  input wire logic [7:0] o_lock_level,
  input wire logic o_nvm_save_req,
  input wire logic o_smbalert_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic tk = i_cmd_valid && o_cmd_ready;
  wire logic wr1 = tk && i_cmd_kind == 3'h1;
  a_feat_read: assert property (tk && i_cmd_kind == 3'h3 &&
    i_cmd_code == 8'h19 |=> o_rvalid && o_rdata == 8'hD0)
    else $error("bad feature byte");
  a_feat_write: assert property (wr1 && i_cmd_code == 8'h19
    |=> o_invalid_data && !o_write_ok) else $error("feature write taken");
  a_lock_bad: assert property (wr1 && i_cmd_code == 8'h10 &&
    !(i_wdata_lo inside {8'h00, 8'h20, 8'h40, 8'h80})
    |=> o_invalid_data ##0 $stable(o_lock_level)) else $error("bad lock taken");
  a_lock_top: assert property (wr1 && o_lock_level == 8'h80 &&
    !(i_cmd_code inside {8'h10, 8'h15, 8'h19, 8'h1B})
    |=> o_lock_reject && $stable(o_phase)) else $error("lock not kept");
  a_phase_bad: assert property (wr1 && i_cmd_code == 8'h04 &&
    o_lock_level == 8'h00 && i_wdata_lo > 8'h03 && i_wdata_lo != 8'hFF
    |=> o_invalid_data && $stable(o_phase)) else $error("bad phase taken");
  a_read_lock: assert property (tk && i_cmd_kind == 3'h3 &&
    i_cmd_code == 8'h10 |=> o_rvalid && o_rdata == o_lock_level)
    else $error("lock read wrong");
  a_save_start: assert property (tk && i_cmd_kind == 3'h0 &&
    i_cmd_code == 8'h15 |=> o_nvm_save_req && !o_cmd_ready)
    else $error("save not started");
  a_mask_phase: assert property (tk && i_cmd_code == 8'h1B &&
    o_phase != 8'hFF && (i_cmd_kind inside {3'h3, 3'h4} ||
    o_lock_level == 8'h00 && i_cmd_kind <= 3'h2)
    |=> o_unsupported_cmd) else $error("mask with phase");
  a_alert_cause: assert property (o_smbalert_oe |->
    i_status != 32'h0) else $error("alert without status");
  c_save: cover property (o_nvm_save_req);
  c_reject: cover property (o_lock_reject);
  c_unsup: cover property (o_unsupported_cmd);
endmodule // pmbus_config_checker
bind pmbus_config_command_group pmbus_config_checker u_pmbus_config_checker (
  .i_clk, .i_rst, .i_cmd_valid, .i_cmd_kind, .i_cmd_code, .i_wdata_lo,
  .i_status, .o_cmd_ready, .o_rvalid, .o_rdata, .o_write_ok, .o_lock_reject,
  .o_invalid_data, .o_unsupported_cmd, .o_phase, .o_lock_level,
  .o_nvm_save_req, .o_smbalert_oe);
`default_nettype wire

// File: testbench/pmbus_config_command_group_bench.sv
// self-checking bench for the config command group
`timescale 1ns/1ps
`default_nettype none
module pmbus_config_command_group_bench;
  logic i_clk, i_rst, i_nvm_done;
  logic [2:0] i_phase_count;
  logic [31:0] i_status;
  wire i_cmd_valid, hung, o_cmd_ready, o_rvalid, o_write_ok, o_lock_reject;
  wire o_invalid_data, o_unsupported_cmd, o_nvm_save_req, o_nvm_load_req;
  wire o_regulation_off, o_strap_apply, o_smbalert_out, o_smbalert_oe;
  wire [2:0] i_cmd_kind;
  wire [7:0] i_cmd_code, i_wdata_lo, i_wdata_hi, o_rdata;
  wire [7:0] o_phase, o_lock_level;
  int error_cnt = 0;
  int cmp_count = 0;
  pmbus_config_command_group u_pmbus_config_command_group (.i_clk, .i_rst,
    .i_cmd_valid, .i_cmd_kind, .i_cmd_code, .i_wdata_lo, .i_wdata_hi,
    .i_phase_count, .i_status, .i_nvm_done, .o_cmd_ready, .o_rvalid, .o_rdata,
    .o_write_ok, .o_lock_reject, .o_invalid_data, .o_unsupported_cmd, .o_phase,
    .o_lock_level, .o_nvm_save_req, .o_nvm_load_req, .o_regulation_off,
    .o_strap_apply, .o_smbalert_out, .o_smbalert_oe);
  pmbus_host_model u_pmbus_host_model (.i_clk, .i_ready(o_cmd_ready),
    .o_valid(i_cmd_valid), .o_kind(i_cmd_kind), .o_code(i_cmd_code),
    .o_lo(i_wdata_lo), .o_hi(i_wdata_hi), .o_hung(hung));
  task finish_test;
    begin
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task run(input logic [2:0] k, input logic [7:0] c, l, h);
    u_pmbus_host_model.cmd(k, c, l, h);
  endtask
  task wait_idle;
    int n;
    begin
      n = 0;
      while (o_cmd_ready !== 1'b1 && n < 50) begin
        n++;
        @(negedge i_clk);
      end
      chk(o_cmd_ready, 1'b1);
      if (o_cmd_ready !== 1'b1)
        finish_test;
    end
  endtask
  task s_phase;
    run(3'h1, 8'h04, 8'h01, 8'h00);
    chk({o_write_ok, o_phase}, 16'h101);
    run(3'h1, 8'h04, 8'h02, 8'h00);
    chk({o_invalid_data, o_phase}, 16'h101);
    run(3'h1, 8'h04, 8'h05, 8'h00);
    chk({o_invalid_data, o_phase}, 16'h101);
    run(3'h1, 8'h04, 8'hFF, 8'h00);
    chk(o_phase, 8'hFF);
    run(3'h3, 8'h19, 8'h00, 8'h00);
    chk({o_rvalid, o_rdata}, 16'h1D0);
    run(3'h1, 8'h19, 8'h00, 8'h00);
    chk({o_invalid_data, o_write_ok}, 16'h2);
  endtask
  task s_lock;
    logic [7:0] lv [4];
    logic [7:0] cd [4];
    logic [3:0] ok [4];
    logic hit;
    begin
      lv = '{8'h80, 8'h40, 8'h20, 8'h00};
      cd = '{8'h01, 8'h02, 8'h21, 8'h04};
      ok = '{4'h0, 4'h1, 4'h7, 4'hF};
      for (int i = 0; i < 4; i++) begin
        run(3'h1, 8'h10, lv[i], 8'h00);
        run(3'h3, 8'h10, 8'h00, 8'h00);
        chk({o_rvalid, o_rdata}, {8'h01, lv[i]});
        for (int j = 0; j < 4; j++) begin
          run(j == 2 ? 3'h2 : 3'h1, cd[j], 8'h00, 8'h00);
          hit = ok[i][j];
          chk({o_write_ok, o_lock_reject}, {hit, !hit});
        end
        chk(o_phase, i == 3 ? 8'h00 : 8'hFF);
      end
      run(3'h1, 8'h10, 8'h10, 8'h00);
      chk({o_invalid_data, o_lock_level}, 16'h100);
      run(3'h1, 8'h04, 8'hFF, 8'h00);
    end
  endtask
  task s_nvm;
    run(3'h0, 8'h15, 8'h00, 8'h00);
    chk({o_write_ok, o_nvm_save_req, o_cmd_ready}, 16'h6);
    repeat (5) @(negedge i_clk);
    chk(o_cmd_ready, 1'b0);
    @(posedge i_clk) i_nvm_done <= 1'b1;
    @(posedge i_clk) i_nvm_done <= 1'b0;
    wait_idle;
    run(3'h0, 8'h16, 8'h00, 8'h00);
    chk({o_nvm_load_req, o_regulation_off, o_cmd_ready}, 16'h6);
    @(posedge i_clk) i_nvm_done <= 1'b1;
    @(posedge i_clk) i_nvm_done <= 1'b0;
    @(negedge i_clk);
    chk(o_strap_apply, 1'b1);
    wait_idle;
  endtask
  task s_mask;
    @(posedge i_clk) i_status <= 32'h0000_0004;
    @(negedge i_clk);
    chk({o_smbalert_oe, o_smbalert_out}, 16'h2);
    run(3'h2, 8'h1B, 8'h7A, 8'hFF);
    chk({o_write_ok, o_smbalert_oe}, 16'h2);
    run(3'h4, 8'h1B, 8'h7A, 8'h00);
    chk({o_rvalid, o_rdata}, 16'h1FC);
    run(3'h1, 8'h04, 8'h00, 8'h00);
    run(3'h2, 8'h1B, 8'h7A, 8'h00);
    chk(o_unsupported_cmd, 1'b1);
    run(3'h1, 8'h04, 8'hFF, 8'h00);
    run(3'h4, 8'h1B, 8'h7A, 8'h00);
    chk(o_rdata, 8'hFC);
  endtask
  always @(posedge hung) begin
    error_cnt++;
    finish_test;
  end
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    i_rst = 1'b1;
    i_nvm_done = 1'b0;
    i_phase_count = 3'h2;
    i_status = 32'h0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk({o_phase, o_lock_level}, 16'hFF00);
    s_phase;
    s_lock;
    s_nvm;
    s_mask;
    finish_test;
  end
endmodule // pmbus_config_command_group_bench
`default_nettype wire

// File: testbench/pmbus_host_model.sv
// host side model issuing commands on the command port
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic [2:0] o_kind,
  output logic [7:0] o_code,
  output logic [7:0] o_lo,
  output logic [7:0] o_hi,
  output logic o_hung
);
  initial begin
    {o_valid, o_kind, o_code, o_lo, o_hi, o_hung} = 29'h0000000;
  end
  // code and data bytes held whole until taken
  task cmd(input logic [2:0] k, input logic [7:0] c, l, h);
    int n;
    begin
      @(posedge i_clk);
      {o_valid, o_kind, o_code, o_lo, o_hi} <= {1'b1, k, c, l, h};
      n = 0;
      @(negedge i_clk);
      while (i_ready !== 1'b1 && n < 200) begin
        n++;
        @(negedge i_clk);
      end
      if (n == 200)
        o_hung = 1'b1;
      @(posedge i_clk);
      o_valid <= 1'b0;
      @(negedge i_clk);
    end
  endtask
endmodule // pmbus_host_model
`default_nettype wire
